// File: core/pacl_pkg.sv
// constants, offsets and types shared by the port acl / mirror / priority bank
package pacl_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int PA_NPORT = 7; // ports 1..7 carry a register set
  localparam int PA_ENTRY_BYTES = 16; // bytes in one acl table entry
  localparam int PA_ENTRY_W = 128; // bits in one acl table entry
  localparam int PA_MEM_AW = 7; // {port, entry index}
  localparam int PA_MEM_DEPTH = 128; // 8 port slots of 16 entries
  localparam int PA_NSRC = 5; // priority classification sources

  // ----------------------------------------------------------------
  // address layout: register index = haddr[16:2], port in index[14:12]
  // ----------------------------------------------------------------
  localparam int PA_IDX_LSB = 2;
  localparam int PA_IDX_MSB = 16;
  localparam int PA_PORT_LSB = 12;
  localparam logic [11:0] PA_OFF_ACL_DATA = 12'h600; // 0x600..0x60F
  localparam logic [11:0] PA_OFF_BE_MSB = 12'h610;
  localparam logic [11:0] PA_OFF_BE_LSB = 12'h611;
  localparam logic [11:0] PA_OFF_ACL_CTL = 12'h612;
  localparam logic [11:0] PA_OFF_MIRROR = 12'h800;
  localparam logic [11:0] PA_OFF_PRIO = 12'h801;
  localparam logic [11:0] PA_OFF_DFLT = 12'h802;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PA_CTL_WR_DONE = 6;
  localparam int PA_CTL_RD_DONE = 5;
  localparam int PA_CTL_DIR = 4;
  localparam int PA_MIR_RX = 6;
  localparam int PA_MIR_TX = 5;
  localparam int PA_MIR_SNIFFER = 1;
  localparam int PA_PRI_HIGH = 7;
  localparam int PA_PRI_OR = 6;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] PA_CFG_RST = 8'h00;
  localparam logic PA_DONE_RST = 1'b1; // both status bits come up complete
  localparam logic [7:0] PA_MIR_MASK = 8'h62;
  localparam logic [7:0] PA_PRI_MASK = 8'hDF;
  localparam logic [7:0] PA_DFLT_MASK = 8'h07;
  localparam logic PA_RESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ACC_IDLE, ACC_WR, ACC_RD, ACC_CAP} pacl_acc_e;
  typedef enum logic [1:0] {PICK_FIRST, PICK_OR, PICK_MAX} pacl_pick_e;

endpackage : pacl_pkg

// File: core/pacl_mem_if.sv
// carrier between the access sequencer and the acl table memory
interface pacl_mem_if #(
  parameter int AW = pacl_pkg::PA_MEM_AW,
  parameter int W = pacl_pkg::PA_ENTRY_W
);
  logic wr; // one-cycle entry write
  logic rd; // one-cycle entry read, data valid next cycle
  logic [AW-1:0] addr; // {port, entry index}
  logic [W/8-1:0] be; // per-byte write enables
  logic [W-1:0] wdata; // entry to write
  logic [W-1:0] rdata; // registered read data
  modport ctl (output wr, rd, addr, be, wdata, input rdata);
  modport mem (input wr, rd, addr, be, wdata, output rdata);
endinterface : pacl_mem_if

// File: core/pacl_mem.sv
// acl table storage with byte write enables and registered read data
module pacl_mem
  import pacl_pkg::*;
#(
  parameter int DEPTH = PA_MEM_DEPTH,
  parameter int W = PA_ENTRY_W
) (
  input logic sys_clk,
  input logic rst_b,
  pacl_mem_if.mem m
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [W-1:0] mem_q [DEPTH]; // table entries, no reset (data only)
  logic [W-1:0] rdata_q; // read data register

  // byte-masked write; unselected bytes keep their old contents
  always_ff @(posedge sys_clk) begin
    if (m.wr) begin
      for (int k = 0; k < W / 8; k++) begin
        if (m.be[k]) begin
          mem_q[m.addr][8*k+:8] <= m.wdata[8*k+:8];
        end
      end
    end
  end

  // read data always leaves from a register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (m.rd) begin
      rdata_q <= mem_q[m.addr];
    end
  end

  assign m.rdata = rdata_q;

endmodule : pacl_mem

// File: core/pacl_regs.sv
// per-port acl access, mirroring and priority select registers on ahb-lite
module pacl_regs
  import pacl_pkg::*;
#(
  parameter int NPORT = PA_NPORT
) (
  input logic sys_clk,
  input logic rst_b,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input logic pkt_vld,
  input logic [2:0] pkt_port,
  input logic pkt_rx,
  input logic glob_mirror_en,
  input logic [PA_NSRC-1:0] cls_src_vld,
  input logic [3*PA_NSRC-1:0] cls_src_pri,
  output logic res_vld,
  output logic [2:0] res_port,
  output logic [2:0] res_pri,
  output logic res_monitor,
  output logic [NPORT-1:0] res_sniff_map
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // port field of a register index is one of the populated ports
  function automatic logic port_ok(input logic [2:0] pt);
    return (pt != 3'h0) && (pt <= 3'(NPORT));
  endfunction : port_ok
  // combine the enabled classifier results in the given manner
  function automatic logic [2:0] pri_pick(input logic [PA_NSRC-1:0] en,
                                          input logic [3*PA_NSRC-1:0] pri,
                                          input pacl_pick_e mode);
    logic [2:0] r;
    logic hit;
    r = 3'h0;
    hit = 1'b0;
    for (int k = 0; k < PA_NSRC; k++) begin
      // or merges, max keeps the larger, first keeps the lowest enabled source
      if (en[k] && mode == PICK_OR) r = r | pri[3*k+:3];
      if (en[k] && mode == PICK_MAX && pri[3*k+:3] > r) r = pri[3*k+:3];
      if (en[k] && mode == PICK_FIRST && !hit) r = pri[3*k+:3];
      hit = hit | en[k];
    end
    return r;
  endfunction : pri_pick
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] acl_q [1:NPORT][PA_ENTRY_BYTES]; // entry staging bytes
  logic [7:0] be_msb_q [1:NPORT]; // byte enables for bytes 0..7
  logic [7:0] be_lsb_q [1:NPORT]; // byte enables for bytes 8..15
  logic dir_q [1:NPORT]; // 1 write, 0 read
  logic [3:0] aidx_q [1:NPORT]; // table entry index
  logic wr_done_q [1:NPORT]; // write complete status
  logic rd_done_q [1:NPORT]; // read complete status
  logic [7:0] mir_q [1:NPORT]; // mirroring control
  logic [7:0] pri_q [1:NPORT]; // priority select control
  logic [7:0] dflt_q [1:NPORT]; // default priority in bits 2:0
  // bus data-phase state
  logic dp_vld_q; // a transfer is in its data phase
  logic dp_wr_q; // that transfer is a write
  logic dp_ok_q; // its address is word aligned and in range
  logic [14:0] dp_idx_q; // register index of that transfer
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  // access sequencer state
  pacl_acc_e acc_q; // current step of the indirect access
  logic [2:0] aport_q; // port being served
  logic [3:0] eidx_q; // table entry being served
  logic [15:0] be_q; // {msb, lsb} enables latched at start
  // result registers
  logic res_vld_q;
  logic [2:0] res_port_q;
  logic [2:0] res_pri_q;
  logic res_monitor_q;
  logic [NPORT-1:0] res_sniff_q;
  pacl_mem_if m ();
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire aph = hsel & htrans[1] & hready; // address phase taken
  wire aph_ok = (haddr[31:17] == 15'h0) & (haddr[1:0] == 2'h0);
  wire [2:0] dport = dp_idx_q[14:PA_PORT_LSB];
  wire [11:0] doff = dp_idx_q[11:0];
  wire dsel = dp_vld_q & dp_ok_q & port_ok(dport);
  wire wr_en = dsel & dp_wr_q & hready; // write lands at end of data phase
  wire rd_go = dp_vld_q & !dp_wr_q & !hreadyout_q; // the single wait cycle
  wire [7:0] wdat = hwdata[7:0];
  wire w_data = wr_en & (doff[11:4] == PA_OFF_ACL_DATA[11:4]);
  wire w_bemsb = wr_en & (doff == PA_OFF_BE_MSB);
  wire w_belsb = wr_en & (doff == PA_OFF_BE_LSB);
  wire w_ctl = wr_en & (doff == PA_OFF_ACL_CTL);
  wire w_mir = wr_en & (doff == PA_OFF_MIRROR);
  wire w_pri = wr_en & (doff == PA_OFF_PRIO);
  wire w_dflt = wr_en & (doff == PA_OFF_DFLT);
  // a start arriving mid-access is stored but does not launch a second one
  wire start = w_belsb & (acc_q == ACC_IDLE);
  wire start_dir = dir_q[dport];
  // read data selection; unmapped offsets, port 0 and reserved bits read zero
  wire [7:0] ctl_byte = {1'b0, wr_done_q[dport], rd_done_q[dport], dir_q[dport], aidx_q[dport]};
  wire [7:0] rd_byte = !dsel ? 8'h00 :
                       (doff[11:4] == PA_OFF_ACL_DATA[11:4]) ? acl_q[dport][doff[3:0]] :
                       (doff == PA_OFF_BE_MSB) ? be_msb_q[dport] :
                       (doff == PA_OFF_BE_LSB) ? be_lsb_q[dport] :
                       (doff == PA_OFF_ACL_CTL) ? ctl_byte :
                       (doff == PA_OFF_MIRROR) ? mir_q[dport] :
                       (doff == PA_OFF_PRIO) ? pri_q[dport] :
                       (doff == PA_OFF_DFLT) ? dflt_q[dport] : 8'h00;
  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // reads take one wait state so that hrdata comes from a flop
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dp_vld_q <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_ok_q <= 1'b0;
      dp_idx_q <= '0;
      hrdata_q <= '0;
      hreadyout_q <= 1'b1;
      hresp_q <= PA_RESP_OKAY;
    end else begin
      if (hready) begin
        dp_vld_q <= aph;
        dp_wr_q <= hwrite;
        dp_ok_q <= aph_ok;
        dp_idx_q <= haddr[PA_IDX_MSB:PA_IDX_LSB];
        hreadyout_q <= !(aph & !hwrite);
      end else if (rd_go) begin
        hrdata_q <= {24'h0, rd_byte};
        hreadyout_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-port configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int p = 1; p <= NPORT; p++) begin
        be_msb_q[p] <= PA_CFG_RST;
        be_lsb_q[p] <= PA_CFG_RST;
        dir_q[p] <= 1'b0;
        aidx_q[p] <= 4'h0;
        mir_q[p] <= PA_CFG_RST;
        pri_q[p] <= PA_CFG_RST;
        dflt_q[p] <= PA_CFG_RST;
      end
    end else begin
      for (int p = 1; p <= NPORT; p++) begin
        if (dport == 3'(p)) begin
          if (w_bemsb) be_msb_q[p] <= wdat;
          if (w_belsb) be_lsb_q[p] <= wdat;
          if (w_ctl) dir_q[p] <= wdat[PA_CTL_DIR];
          if (w_ctl) aidx_q[p] <= wdat[3:0];
          if (w_mir) mir_q[p] <= wdat & PA_MIR_MASK;
          if (w_pri) pri_q[p] <= wdat & PA_PRI_MASK;
          if (w_dflt) dflt_q[p] <= wdat & PA_DFLT_MASK;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // indirect table access
  // ----------------------------------------------------------------
  // sequencer: start, one memory cycle, capture for reads
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      acc_q <= ACC_IDLE;
      aport_q <= 3'h0;
      eidx_q <= 4'h0;
      be_q <= '0;
    end else begin
      case (acc_q)
        ACC_IDLE: begin
          if (start) begin
            acc_q <= start_dir ? ACC_WR : ACC_RD;
            aport_q <= dport;
            eidx_q <= aidx_q[dport];
            be_q <= {be_msb_q[dport], wdat};
          end
        end
        ACC_WR: acc_q <= ACC_IDLE;
        ACC_RD: acc_q <= ACC_CAP;
        default: acc_q <= ACC_IDLE;
      endcase
    end
  end
  // status bits: cleared by a start, set when the step completes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int p = 1; p <= NPORT; p++) begin
        wr_done_q[p] <= PA_DONE_RST;
        rd_done_q[p] <= PA_DONE_RST;
      end
    end else begin
      for (int p = 1; p <= NPORT; p++) begin
        if (start && start_dir && dport == 3'(p)) wr_done_q[p] <= 1'b0;
        if (acc_q == ACC_WR && aport_q == 3'(p)) wr_done_q[p] <= 1'b1;
        if (start && !start_dir && dport == 3'(p)) rd_done_q[p] <= 1'b0;
        if (acc_q == ACC_CAP && aport_q == 3'(p)) rd_done_q[p] <= 1'b1;
      end
    end
  end
  // staging bytes: bus writes, then captured read data wins the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int p = 1; p <= NPORT; p++) begin
        for (int k = 0; k < PA_ENTRY_BYTES; k++) acl_q[p][k] <= 8'h00;
      end
    end else begin
      for (int p = 1; p <= NPORT; p++) begin
        if (w_data && dport == 3'(p)) acl_q[p][doff[3:0]] <= wdat;
        for (int k = 0; k < PA_ENTRY_BYTES; k++) begin
          if (acc_q == ACC_CAP && aport_q == 3'(p) && be_q[15-k]) begin
            acl_q[p][k] <= m.rdata[8*k+:8];
          end
        end
      end
    end
  end
  // memory request; enable bit j selects byte 15-j of the entry
  always_comb begin
    m.wr = (acc_q == ACC_WR);
    m.rd = (acc_q == ACC_RD);
    m.addr = {aport_q, eidx_q};
    m.be = '0;
    m.wdata = '0;
    for (int k = 0; k < PA_ENTRY_BYTES; k++) begin
      m.be[k] = be_q[15-k];
      m.wdata[8*k+:8] = acl_q[aport_q][k];
    end
  end
  pacl_mem u_mem (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .m(m)
  );
  // ----------------------------------------------------------------
  // mirroring and priority classification
  // ----------------------------------------------------------------
  wire pkt_ok = port_ok(pkt_port);
  wire [7:0] pcfg = pkt_ok ? pri_q[pkt_port] : 8'h00;
  wire [7:0] pmir = pkt_ok ? mir_q[pkt_port] : 8'h00;
  wire [2:0] pdflt = pkt_ok ? dflt_q[pkt_port][2:0] : 3'h0;
  wire [PA_NSRC-1:0] src_en = pcfg[PA_NSRC-1:0] & cls_src_vld;
  wire [2:0] cls_max = pri_pick(src_en, cls_src_pri, PICK_MAX);
  wire [2:0] cls_or = pri_pick(src_en, cls_src_pri, PICK_OR);
  wire [2:0] cls_first = pri_pick(src_en, cls_src_pri, PICK_FIRST);
  // mirroring only acts while the global enable is on
  // receive sniff bit 6
  wire mon = glob_mirror_en & (pkt_rx ? pmir[PA_MIR_RX] : pmir[PA_MIR_TX]);
  logic [NPORT-1:0] sniff_vec;
  // sniffer ports: every port whose sniffer bit is set
  always_comb begin
    for (int p = 1; p <= NPORT; p++) sniff_vec[p-1] = mir_q[p][PA_MIR_SNIFFER];
  end
  wire [2:0] pri_sel = (src_en == '0) ? pdflt :
                       pcfg[PA_PRI_HIGH] ? cls_max :
                       pcfg[PA_PRI_OR] ? cls_or : cls_first;
  // one result per packet, one cycle after it is offered
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      res_vld_q <= 1'b0;
      res_port_q <= 3'h0;
      res_pri_q <= 3'h0;
      res_monitor_q <= 1'b0;
      res_sniff_q <= '0;
    end else begin
      res_vld_q <= pkt_vld;
      if (pkt_vld) begin
        res_port_q <= pkt_port;
        res_pri_q <= pri_sel;
        res_monitor_q <= mon;
        res_sniff_q <= mon ? sniff_vec : '0;
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign res_vld = res_vld_q;
  assign res_port = res_port_q;
  assign res_pri = res_pri_q;
  assign res_monitor = res_monitor_q;
  assign res_sniff_map = res_sniff_q;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_WR_DONE: assert property ((acc_q == ACC_WR) |->
    !wr_done_q[aport_q] ##1 wr_done_q[aport_q]) else $error("write status wrong");
  AST_RD_DONE: assert property ((acc_q == ACC_RD) |->
    !rd_done_q[aport_q] ##2 rd_done_q[aport_q]) else $error("read status wrong");
  AST_DIR: assert property (start |=>
    (acc_q == ($past(start_dir) ? ACC_WR : ACC_RD))) else $error("bad direction");
  AST_START: assert property ((acc_q == ACC_IDLE && !start) |=>
    (acc_q == ACC_IDLE)) else $error("access without start");
  AST_RX: assert property ((pkt_vld && pkt_rx && mon) |=>
    (res_monitor_q && res_sniff_q == $past(sniff_vec))) else $error("rx sniff lost");
  AST_TX: assert property ((pkt_vld && !pkt_rx) |=>
    (res_monitor_q == $past(glob_mirror_en && pmir[PA_MIR_TX]))) else $error("tx sniff");
  AST_SNIF: assert property ((res_vld_q && !res_monitor_q) |->
    (res_sniff_q == '0)) else $error("unmonitored packet mirrored");
  AST_HIGH: assert property ((pkt_vld && src_en != '0 && pcfg[PA_PRI_HIGH]) |=>
    (res_pri_q == $past(cls_max))) else $error("highest priority wrong");
  AST_OR: assert property ((pkt_vld && src_en != '0 && pcfg[7:6] == 2'b01) |=>
    (res_pri_q == $past(cls_or))) else $error("or priority wrong");
  AST_DFLT: assert property ((pkt_vld && src_en == '0) |=>
    (res_pri_q == $past(pdflt))) else $error("default priority wrong");
  AST_RDWAIT: assert property ((aph && !hwrite) |=>
    !hreadyout_q ##1 hreadyout_q) else $error("read wait state wrong");

endmodule : pacl_regs

// File: testbench/pacl_regs_tb_top.sv
// self-checking bench for the port acl / mirror / priority register bank
module pacl_regs_tb_top
  import pacl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0; // 125 MHz
  logic rst_b = 1'b0; // synchronous, active low
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2; // word transfers only
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pkt_vld = 1'b0;
  logic [2:0] pkt_port = 3'h0;
  logic pkt_rx = 1'b0;
  logic glob_mirror_en = 1'b0;
  logic [PA_NSRC-1:0] cls_src_vld = '0;
  logic [3*PA_NSRC-1:0] cls_src_pri = '0;
  logic res_vld;
  logic [2:0] res_port;
  logic [2:0] res_pri;
  logic res_monitor;
  logic [PA_NPORT-1:0] res_sniff_map;
  int bad_count = 0; // mismatches
  int compares = 0; // comparisons made
  int cyc = 0; // cycle counter for the hang guard
  logic [31:0] seed = 32'h16A9; // lfsr state
  logic [7:0] mir_c [8] = '{default: 8'h00}; // bench copy, slot 0 stays zero
  logic [7:0] pri_c [8] = '{default: 8'h00};
  logic [2:0] dfl_c [8] = '{default: 3'h0};
  logic [7:0] ent [16]; // acl entry written by the bench
  logic [3:0] idx; // acl entry index
  logic [31:0] v; // packet stimulus word
  logic mon; // expected monitored flag
  logic [6:0] map; // expected sniffer map

  always #4 sys_clk = ~sys_clk;

  // hready is the single slave's own ready
  pacl_regs dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pkt_vld(pkt_vld),
    .pkt_port(pkt_port), .pkt_rx(pkt_rx), .glob_mirror_en(glob_mirror_en),
    .cls_src_vld(cls_src_vld), .cls_src_pri(cls_src_pri), .res_vld(res_vld),
    .res_port(res_port), .res_pri(res_pri), .res_monitor(res_monitor),
    .res_sniff_map(res_sniff_map));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // byte address of a per-port register
  function automatic logic [31:0] ra(input logic [2:0] p, input logic [11:0] o);
    return {15'h0, p, o, 2'b00};
  endfunction : ra

  // priority expected from the port's select byte and the sources
  function automatic logic [2:0] exp_pri(input logic [7:0] c, input logic [4:0] sv,
                                         input logic [14:0] sp, input logic [2:0] d);
    logic [2:0] r;
    logic hit;
    r = 3'h0;
    hit = 1'b0;
    for (int k = 0; k < 5; k++) begin
      if (c[k] && sv[k]) begin
        if (c[7]) begin
          r = (sp[3*k+:3] > r) ? sp[3*k+:3] : r;
        end else if (c[6]) begin
          r = r | sp[3*k+:3];
        end else if (!hit) begin
          r = sp[3*k+:3];
        end
        hit = 1'b1;
      end
    end
    return hit ? r : d;
  endfunction : exp_pri

  // one single ahb transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [2:0] p, input logic [11:0] o, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, ra(p, o), d, r);
  endtask : wr

  task automatic rd(input logic [2:0] p, input logic [11:0] o, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, ra(p, o), 8'h00, r);
    chk(r, {24'h0, e});
  endtask : rd

  // poll a status bit of the acl control byte, bounded
  task automatic poll(input logic [2:0] p, input int b);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      bus(1'b0, ra(p, PA_OFF_ACL_CTL), 8'h00, r);
      n++;
    end while (r[b] !== 1'b1 && n < 20);
    chk({31'h0, r[b]}, 32'h1);
  endtask : poll

  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int p = 1; p <= 7; p++) begin
      rd(p[2:0], PA_OFF_ACL_CTL, 8'h60);
      rd(p[2:0], PA_OFF_MIRROR, 8'h00);
      wr(p[2:0], PA_OFF_MIRROR, 8'hFF);
      rd(p[2:0], PA_OFF_MIRROR, 8'h62);
      wr(p[2:0], PA_OFF_PRIO, 8'hFF);
      rd(p[2:0], PA_OFF_PRIO, 8'hDF);
      wr(p[2:0], PA_OFF_ACL_CTL, 8'hFF);
      rd(p[2:0], PA_OFF_ACL_CTL, 8'h7F);
    end
    // unmapped places read zero
    rd(3'h0, PA_OFF_MIRROR, 8'h00);
    rd(3'h2, 12'h803, 8'h00);
    // indirect write of a whole entry, then a masked read back
    seed = lfsr(seed);
    idx = seed[3:0];
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      ent[k] = seed[7:0];
      wr(3'h3, PA_OFF_ACL_DATA + 12'(k), ent[k]);
    end
    wr(3'h3, PA_OFF_BE_MSB, 8'hFF);
    wr(3'h3, PA_OFF_ACL_CTL, {4'h1, idx});
    wr(3'h3, PA_OFF_BE_LSB, 8'hFF);
    poll(3'h3, PA_CTL_WR_DONE);
    for (int k = 0; k < 16; k++) begin
      wr(3'h3, PA_OFF_ACL_DATA + 12'(k), ~ent[k]);
    end
    wr(3'h3, PA_OFF_ACL_CTL, {4'h0, idx});
    wr(3'h3, PA_OFF_BE_MSB, 8'h0F);
    wr(3'h3, PA_OFF_BE_LSB, 8'hFF);
    poll(3'h3, PA_CTL_RD_DONE);
    rd(3'h3, PA_OFF_ACL_CTL, {4'h6, idx});
    for (int k = 0; k < 16; k++) begin
      rd(3'h3, PA_OFF_ACL_DATA + 12'(k), (k < 4) ? ~ent[k] : ent[k]);
    end
    // packet path under random configurations
    for (int n = 0; n < 4; n++) begin
      for (int p = 1; p <= 7; p++) begin
        seed = lfsr(seed);
        mir_c[p] = seed[7:0] & PA_MIR_MASK;
        pri_c[p] = (n == 0) ? (8'h01 << seed[10:8]) & PA_PRI_MASK : seed[15:8] & PA_PRI_MASK;
        dfl_c[p] = seed[18:16];
        wr(p[2:0], PA_OFF_MIRROR, mir_c[p]);
        wr(p[2:0], PA_OFF_PRIO, pri_c[p]);
        wr(p[2:0], PA_OFF_DFLT, {5'h0, dfl_c[p]});
      end
      for (int i = 0; i < 60; i++) begin
        seed = lfsr(seed);
        v = seed;
        @(posedge sys_clk);
        pkt_port <= v[2:0];
        pkt_rx <= v[3];
        glob_mirror_en <= v[4] | v[25];
        cls_src_vld <= v[9:5];
        cls_src_pri <= v[24:10];
        pkt_vld <= 1'b1;
        @(posedge sys_clk);
        pkt_vld <= 1'b0;
        #1;
        mon = (v[4] | v[25]) & (v[3] ? mir_c[v[2:0]][6] : mir_c[v[2:0]][5]);
        for (int q = 1; q <= 7; q++) begin
          map[q-1] = mon & mir_c[q][1];
        end
        chk({29'h0, res_port}, {29'h0, v[2:0]});
        chk({31'h0, res_vld}, 32'h1);
        chk({31'h0, res_monitor}, {31'h0, mon});
        chk({25'h0, res_sniff_map}, {25'h0, map});
        chk({29'h0, res_pri}, {29'h0, exp_pri(pri_c[v[2:0]], v[9:5], v[24:10],
          dfl_c[v[2:0]])});
      end
      // result strobe lasts one cycle, the port echo holds until the next packet
      @(posedge sys_clk);
      #1;
      chk({31'h0, res_vld}, 32'h0);
      chk({29'h0, res_port}, {29'h0, v[2:0]});
    end
    close_out();
  end

endmodule : pacl_regs_tb_top
